//--- include/mct_pkg.sv
package mct_pkg;
  // register offsets
  localparam logic [7:0] ADDR_WINDOW = 8'h00;
  localparam logic [7:0] ADDR_PCL = 8'h01;
  localparam logic [7:0] ADDR_PCH = 8'h02;
  localparam logic [7:0] ADDR_STATUS = 8'h03;
  localparam logic [7:0] ADDR_PTR = 8'h04;
  localparam logic [7:0] ADDR_DIRA = 8'h05;
  localparam logic [7:0] ADDR_PORT_A_DATA = 8'h06;
  localparam logic [7:0] ADDR_DIRB = 8'h07;
  localparam logic [7:0] ADDR_PORT_B_DATA = 8'h08;
  localparam logic [7:0] ADDR_DIRC = 8'h09;
  localparam logic [7:0] ADDR_PORT_C_DATA = 8'h0A;
  localparam logic [7:0] ADDR_T1CTL = 8'h10;
  localparam logic [7:0] ADDR_T1PWM = 8'h11;
  localparam logic [7:0] ADDR_T1RLD = 8'h12;
  localparam logic [7:0] ADDR_TIMER1_COUNT = 8'h2B;
  // status bit positions
  localparam int ST_C = 0;
  localparam int ST_DC = 1;
  localparam int ST_Z = 2;
  localparam int ST_PD = 3;
  localparam int ST_TO = 4;
  // implemented-bit masks and reset values
  localparam logic [7:0] MASK_DIRA = 8'h7F;
  localparam logic [7:0] MASK_PORT_B_DATA = 8'h3F;
  localparam logic [7:0] MASK_T1CTL = 8'hBF;
  localparam logic [7:0] MASK_T1PWM = 8'hEF;
  localparam logic [7:0] RST_DIR = 8'hFF;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [2:0] RST_STATUS_TOPD = 3'h3;
  // field positions
  localparam int T1_EN = 7;
  localparam int T1_EDGE = 3;
  localparam int PWM_MODE = 7;
  localparam int PWM_INIT = 6;
  localparam int PWM_EXT = 5;
  // timer source encodings
  localparam logic [1:0] SRC_EXT_PIN = 2'h0;
  localparam logic [1:0] SRC_XTAL = 2'h1;
  localparam logic [1:0] SRC_RC = 2'h2;
  localparam logic [1:0] SRC_RC_X2 = 2'h3;
  localparam int STACK_DEPTH = 8;
  localparam int PC_W = 11;
  // core program-flow operations
  typedef enum logic [2:0] {
    MCT_PC_STEP = 3'h0,
    MCT_PC_JUMP = 3'h1,
    MCT_PC_CALL = 3'h3,
    MCT_PC_RET = 3'h2,
    MCT_PC_RETI = 3'h6,
    MCT_PC_RETURN_WITH_FLAG = 3'h7,
    MCT_PC_IRQ = 3'h5,
    MCT_PC_HOLD = 3'h4
  } mct_pcop_e;
endpackage

//--- include/mct_stack_if.sv
`timescale 1ns/10ps
interface mct_stack_if;
  logic push;
  logic pop;
  logic [10:0] wdata;
  logic [10:0] rdata;
  modport core (output push, output pop, output wdata, input rdata);
  modport mem (input push, input pop, input wdata, output rdata);
endinterface

//--- verilog/mct_stack.sv
`timescale 1ns/10ps
module mct_stack
  import mct_pkg::*;
#(
  parameter int DEPTH = STACK_DEPTH
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // stack port
  mct_stack_if.mem st
);
  logic [PC_W-1:0] mem_ff [DEPTH];
  logic [$clog2(DEPTH)-1:0] sp_ff;
  logic [PC_W-1:0] rdata_ff;

  // circular pointer, deeper nesting wraps (undefined beyond depth)
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sp_ff <= '0;
    end else if (st.push) begin
      sp_ff <= sp_ff + 1'b1;
    end else if (st.pop) begin
      sp_ff <= sp_ff - 1'b1;
    end
  end

  // entry storage
  always_ff @(posedge clk) begin
    if (st.push) begin
      mem_ff[sp_ff] <= st.wdata;
    end
  end

  // registered top entry, refreshed every cycle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdata_ff <= '0;
    end else if (st.push) begin
      rdata_ff <= st.wdata;
    end else if (st.pop) begin
      rdata_ff <= mem_ff[sp_ff - 3'd2];
    end else begin
      rdata_ff <= mem_ff[sp_ff - 3'd1];
    end
  end

  assign st.rdata = rdata_ff;
endmodule // mct_stack

//--- verilog/mct_regs.sv
`timescale 1ns/10ps
// Contract
// - 11-bit counter, eight 11-bit stack entries
// - low byte and high buffer readable, writable
// - buffer not refreshed on interrupt, reti, return_with_flag
// - buffer reaches counter only on listed events
// - status dest: flags from result; TO, PD locked
// - clearing status yields 000u u1uu; here C, DC and Z take the written 0 unless flag_upd with flag_mask selects them
// - carry: add carry, subtract no-borrow, rotates
// - half-carry from bit 3, no-borrow on subtract
// - zero flag set on zero result
// - power-down and watchdog flags set and cleared
// - pointer addresses indirect window accesses
// - direction 1 input; read pins; write latch
// - port A bit 7 read-only
// - timer enable bit, read-only count, reload latch
// - two-bit clock source selection
// - edge select only for external pin
// - prescaler divides by two to the field
// - mode bit selects pwm or timer
// - initial level bit picks pwm polarity
// - extension bit selects extended pwm
// - pwm interrupt every field plus one pulses
// - window via zero pointer reads 00h, writes nothing
module mct_regs
  import mct_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // register access from core
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // indirect memory access for general registers
  output logic [7:0] mem_addr,
  input wire logic [7:0] mem_rdata,
  // alu flag update
  input wire logic flag_upd,
  input wire logic [2:0] flag_mask,
  input wire logic [2:0] flag_val,
  // power flag events
  input wire logic watchdog_clear_instr,
  input wire logic sleep_instr,
  input wire logic watchdog_overflow,
  // program flow
  input wire logic [2:0] pc_op,
  input wire logic [10:0] pc_target,
  output logic [10:0] pc,
  // port pins
  input wire logic [7:0] port_a_pins,
  input wire logic [7:0] port_b_pins,
  input wire logic [7:0] port_c_pins,
  output logic [7:0] port_a_out,
  output logic [7:0] port_a_oe,
  output logic [7:0] port_b_out,
  output logic [7:0] port_b_oe,
  output logic [7:0] port_c_out,
  output logic [7:0] port_c_oe,
  // timer1 clock sources and event
  input wire logic timer_ext_clock_pin,
  input wire logic xtal_tick,
  input wire logic rc_tick,
  input wire logic doubled_internal_osc,
  input wire logic [7:0] timer1_count,
  output logic timer1_tick,
  output logic timer1_enable,
  output logic timer1_mode_select,
  output logic pwm1_initial_level,
  output logic pwm1_extended_mode,
  output logic [3:0] pwm1_irq_rate,
  output logic [7:0] timer1_reload_latch
);
  logic [PC_W-1:0] pc_ff;
  logic [2:0] pch_ff;
  logic [7:0] status_ff, ptr_ff, dira_ff, dirb_ff, dirc_ff;
  logic [7:0] lata_ff, latb_ff, latc_ff, t1ctl_ff, t1pwm_ff, t1rld_ff;
  logic [7:0] rdata_ff;
  logic [6:0] pre_ff;
  logic ext_prev_ff, tick_ff;
  logic [7:0] eff_addr, rd_val;
  logic wr_win, is_win;
  logic [7:0] pcl_next;
  logic src_evt;
  mct_stack_if st ();

  mct_stack #(.DEPTH(STACK_DEPTH)) u_stack (
    .clk(clk),
    .sys_rst(sys_rst),
    .st(st)
  );

  // indirect window resolves through the pointer
  assign is_win = (reg_addr == ADDR_WINDOW);
  assign eff_addr = is_win ? ptr_ff : reg_addr;
  assign wr_win = reg_wr && !(is_win && ptr_ff == ADDR_WINDOW);
  assign mem_addr = eff_addr;

  // stack control
  assign st.push = (pc_op == MCT_PC_CALL) || (pc_op == MCT_PC_IRQ);
  assign st.pop = (pc_op == MCT_PC_RET) || (pc_op == MCT_PC_RETI)
    || (pc_op == MCT_PC_RETURN_WITH_FLAG);
  assign st.wdata = pc_ff + 11'd1;
  assign pcl_next = pc_ff[7:0] + 8'd1;

  // program counter, 11 bits
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pc_ff <= '0;
    end else if (wr_win && eff_addr == ADDR_PCL) begin
      pc_ff <= {pch_ff, reg_wdata};
    end else begin
      case (pc_op)
        MCT_PC_JUMP, MCT_PC_CALL, MCT_PC_IRQ: pc_ff <= pc_target;
        MCT_PC_RET, MCT_PC_RETI, MCT_PC_RETURN_WITH_FLAG: pc_ff <= st.rdata;
        MCT_PC_STEP: begin
          if (pcl_next == 8'h00) begin
            pc_ff <= {pch_ff, pcl_next};
          end else begin
            pc_ff <= {pc_ff[10:8], pcl_next};
          end
        end
        default: pc_ff <= pc_ff;
      endcase
    end
  end

  // high buffer, loaded from target on jump/call and from stack on ret; held on step, hold, interrupt, reti/return_with_flag
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pch_ff <= '0;
    end else if (wr_win && eff_addr == ADDR_PCH) begin
      pch_ff <= reg_wdata[2:0];
    end else begin
      case (pc_op)
        MCT_PC_JUMP, MCT_PC_CALL: pch_ff <= pc_target[10:8];
        MCT_PC_RET: pch_ff <= st.rdata[10:8];
        MCT_PC_IRQ, MCT_PC_RETI, MCT_PC_RETURN_WITH_FLAG: pch_ff <= pch_ff;
        default: pch_ff <= pch_ff;
      endcase
    end
  end

  // status: alu flags win over write, TO/PD not writable
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      status_ff <= {3'h0, RST_STATUS_TOPD[1:0], 3'h0};
    end else begin
      if (wr_win && eff_addr == ADDR_STATUS) begin
        status_ff[7:5] <= 3'h0;
        for (int i = 0; i < 3; i++) begin
          if (!(flag_upd && flag_mask[i])) begin
            status_ff[i] <= reg_wdata[i];
          end
        end
      end
      if (flag_upd) begin
        for (int i = 0; i < 3; i++) begin
          if (flag_mask[i]) begin
            status_ff[i] <= flag_val[i];
          end
        end
      end
      if (watchdog_overflow) begin
        status_ff[ST_TO] <= 1'b0;
      end else if (watchdog_clear_instr || sleep_instr) begin
        status_ff[ST_TO] <= 1'b1;
      end
      if (sleep_instr) begin
        status_ff[ST_PD] <= 1'b0;
      end else if (watchdog_clear_instr) begin
        status_ff[ST_PD] <= 1'b1;
      end
    end
  end

  // plain writable registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ptr_ff <= RST_ZERO;
      dira_ff <= RST_DIR & MASK_DIRA;
      dirb_ff <= RST_DIR & MASK_PORT_B_DATA;
      dirc_ff <= RST_DIR;
      lata_ff <= RST_ZERO;
      latb_ff <= RST_ZERO;
      latc_ff <= RST_ZERO;
      t1ctl_ff <= RST_ZERO;
      t1pwm_ff <= RST_ZERO;
      t1rld_ff <= RST_ZERO;
    end else if (wr_win) begin
      case (eff_addr)
        ADDR_PTR: ptr_ff <= reg_wdata;
        ADDR_DIRA: dira_ff <= reg_wdata & MASK_DIRA;
        ADDR_PORT_A_DATA: lata_ff <= reg_wdata & MASK_DIRA;
        ADDR_DIRB: dirb_ff <= reg_wdata & MASK_PORT_B_DATA;
        ADDR_PORT_B_DATA: latb_ff <= reg_wdata & MASK_PORT_B_DATA;
        ADDR_DIRC: dirc_ff <= reg_wdata;
        ADDR_PORT_C_DATA: latc_ff <= reg_wdata;
        ADDR_T1CTL: t1ctl_ff <= reg_wdata & MASK_T1CTL;
        ADDR_T1PWM: t1pwm_ff <= reg_wdata & MASK_T1PWM;
        ADDR_T1RLD: t1rld_ff <= reg_wdata;
        default: ptr_ff <= ptr_ff;
      endcase
    end
  end

  // read multiplexer
  always_comb begin
    rd_val = 8'h00;
    case (eff_addr)
      ADDR_WINDOW: rd_val = 8'h00;
      ADDR_PCL: rd_val = pc_ff[7:0];
      ADDR_PCH: rd_val = {5'h00, pch_ff};
      ADDR_STATUS: rd_val = status_ff;
      ADDR_PTR: rd_val = ptr_ff;
      ADDR_DIRA: rd_val = dira_ff;
      ADDR_PORT_A_DATA: rd_val = port_a_pins;
      ADDR_DIRB: rd_val = dirb_ff;
      ADDR_PORT_B_DATA: rd_val = port_b_pins & MASK_PORT_B_DATA;
      ADDR_DIRC: rd_val = dirc_ff;
      ADDR_PORT_C_DATA: rd_val = port_c_pins;
      ADDR_T1CTL: rd_val = t1ctl_ff;
      ADDR_T1PWM: rd_val = t1pwm_ff;
      ADDR_T1RLD: rd_val = t1rld_ff;
      ADDR_TIMER1_COUNT: rd_val = timer1_count;
      default: rd_val = mem_rdata;
    endcase
  end

  // registered read data
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdata_ff <= 8'h00;
    end else begin
      rdata_ff <= rd_val;
    end
  end

  // timer1 source select and edge detect
  always_comb begin
    src_evt = 1'b0;
    case (t1ctl_ff[5:4])
      SRC_EXT_PIN: begin
        src_evt = t1ctl_ff[T1_EDGE] ? (ext_prev_ff && !timer_ext_clock_pin)
          : (!ext_prev_ff && timer_ext_clock_pin);
      end
      SRC_XTAL: src_evt = xtal_tick;
      SRC_RC: src_evt = rc_tick;
      SRC_RC_X2: src_evt = doubled_internal_osc;
      default: src_evt = 1'b0;
    endcase
  end

  // prescaler, divide by 2^field
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ext_prev_ff <= timer_ext_clock_pin; // no false edge after reset
      pre_ff <= '0;
      tick_ff <= 1'b0;
    end else begin
      ext_prev_ff <= timer_ext_clock_pin;
      tick_ff <= 1'b0;
      if (!t1ctl_ff[T1_EN]) begin
        pre_ff <= '0;
      end else if (src_evt) begin
        if ((pre_ff & ((7'h01 << t1ctl_ff[2:0]) - 7'h01)) ==
            ((7'h01 << t1ctl_ff[2:0]) - 7'h01)) begin
          pre_ff <= '0;
          tick_ff <= 1'b1;
        end else begin
          pre_ff <= pre_ff + 7'h01;
        end
      end
    end
  end

  // outputs
  assign reg_rdata = rdata_ff;
  assign pc = pc_ff;
  assign port_a_out = lata_ff;
  assign port_a_oe = ~dira_ff & MASK_DIRA;
  assign port_b_out = latb_ff;
  assign port_b_oe = ~dirb_ff & MASK_PORT_B_DATA;
  assign port_c_out = latc_ff;
  assign port_c_oe = ~dirc_ff;
  assign timer1_tick = tick_ff;
  assign timer1_enable = t1ctl_ff[T1_EN];
  assign timer1_mode_select = t1pwm_ff[PWM_MODE];
  assign pwm1_initial_level = t1pwm_ff[PWM_INIT];
  assign pwm1_extended_mode = t1pwm_ff[PWM_EXT];
  assign pwm1_irq_rate = t1pwm_ff[3:0];
  assign timer1_reload_latch = t1rld_ff;

  // checks
  pcl_jump_a: assert property (@(posedge clk) disable iff (sys_rst)
    (reg_wr && reg_addr == ADDR_PCL) |=> pc_ff[10:8] == $past(pch_ff))
    else $error("low byte write did not jump");
  irq_buf_a: assert property (@(posedge clk) disable iff (sys_rst)
    (pc_op == MCT_PC_IRQ && !reg_wr) |=> $stable(pch_ff))
    else $error("buffer changed on interrupt");
  pd_sleep_a: assert property (@(posedge clk) disable iff (sys_rst)
    (sleep_instr && !watchdog_overflow)
    |=> !status_ff[ST_PD] && status_ff[ST_TO])
    else $error("sleep flags wrong");
  wdt_ovf_a: assert property (@(posedge clk) disable iff (sys_rst)
    watchdog_overflow |=> !status_ff[ST_TO])
    else $error("overflow flag not cleared");
  win_zero_a: assert property (@(posedge clk) disable iff (sys_rst)
    (is_win && ptr_ff == 8'h00) |=> reg_rdata == 8'h00)
    else $error("self window not zero");
  pa7_ro_a: assert property (@(posedge clk) disable iff (sys_rst)
    !lata_ff[7] && !port_a_oe[7])
    else $error("port a bit 7 driven");
  t1_off_a: assert property (@(posedge clk) disable iff (sys_rst)
    !t1ctl_ff[T1_EN] |=> !tick_ff)
    else $error("tick while disabled");
  stat_upper_a: assert property (@(posedge clk) disable iff (sys_rst)
    status_ff[7:5] == 3'h0)
    else $error("status upper bits set");
  cv_call: cover property (@(posedge clk) pc_op == MCT_PC_CALL);
  cv_ret: cover property (@(posedge clk) pc_op == MCT_PC_RET);
  cv_tick: cover property (@(posedge clk) tick_ff);
  cv_win: cover property (@(posedge clk) is_win && reg_wr);
endmodule // mct_regs

//--- tb/mct_mem_model.sv
`timescale 1ns/10ps
// general data memory seen through the indirect window
module mct_mem_model (
  // address from the register bank
  input wire logic [7:0] mem_addr,
  // read data back to the register bank
  output logic [7:0] mem_rdata
);
  // fixed pattern per address so every location reads differently
  assign mem_rdata = mem_addr ^ 8'hA5;
endmodule // mct_mem_model

//--- tb/tb.sv
`timescale 1ns/10ps
module tb;
  import mct_pkg::*;
  logic clk, sys_rst, reg_wr, rd_flag, chk_d, flag_upd, wdc, slp, wdo;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, mem_addr, mem_rdata;
  logic [2:0] flag_mask, flag_val, pc_op;
  logic [10:0] pc_target, pc;
  logic [7:0] pa, pb, pc_pins, a_out, a_oe, b_out, b_oe, c_out, c_oe;
  logic [3:0] src_v, irq_rate;
  logic t_tick, t_en, t_mode, p_init, p_ext;
  logic [7:0] t_cnt, t_rld, v;
  logic [7:0] q[$];
  int errors, num_checks, ticks, t0;

  mct_regs dut_u (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .mem_addr(mem_addr), .mem_rdata(mem_rdata), .flag_upd(flag_upd),
    .flag_mask(flag_mask), .flag_val(flag_val),
    .watchdog_clear_instr(wdc), .sleep_instr(slp),
    .watchdog_overflow(wdo), .pc_op(pc_op), .pc_target(pc_target),
    .pc(pc), .port_a_pins(pa), .port_b_pins(pb), .port_c_pins(pc_pins),
    .port_a_out(a_out), .port_a_oe(a_oe), .port_b_out(b_out),
    .port_b_oe(b_oe), .port_c_out(c_out), .port_c_oe(c_oe),
    .timer_ext_clock_pin(src_v[0]), .xtal_tick(src_v[1]),
    .rc_tick(src_v[2]), .doubled_internal_osc(src_v[3]),
    .timer1_count(t_cnt), .timer1_tick(t_tick), .timer1_enable(t_en),
    .timer1_mode_select(t_mode), .pwm1_initial_level(p_init),
    .pwm1_extended_mode(p_ext), .pwm1_irq_rate(irq_rate),
    .timer1_reload_latch(t_rld));
  mct_mem_model mem_u (.mem_addr(mem_addr), .mem_rdata(mem_rdata));

  // 20 MHz clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic chk(input logic [10:0] seen, input logic [10:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("Error %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    if (errors == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge clk) #1 reg_wr = 1'b0;
    @(posedge clk) #1;
  endtask

  // read: the expected value waits in the queue for the monitor
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    reg_addr = a;
    rd_flag = 1'b1;
    q.push_back(e);
    @(posedge clk) #1 rd_flag = 1'b0;
    @(posedge clk) #1;
  endtask

  task automatic pcop(input logic [2:0] op, input logic [10:0] t);
    pc_op = op;
    pc_target = t;
    @(posedge clk) #1 pc_op = MCT_PC_HOLD;
    @(posedge clk) #1;
  endtask

  task automatic pulse(input int s);
    src_v = 4'h1 << s;
    @(posedge clk) #1 src_v = 4'h0;
    @(posedge clk) #1;
  endtask

  // read data is valid the cycle after the address was sampled
  always @(posedge clk) begin
    if (chk_d) begin
      chk(reg_rdata, q.pop_front());
    end
    chk_d <= rd_flag;
  end

  // timer event counter
  always @(posedge clk) begin
    if (t_tick === 1'b1) begin
      ticks++;
    end
  end

  // hang guard
  initial begin
    #400us;
    errors++;
    stop_test();
  end

  initial begin
    {sys_rst, reg_wr, rd_flag, chk_d, flag_upd, wdc, slp, wdo} = 8'hFF;
    {reg_addr, reg_wdata, flag_mask, flag_val, src_v} = '0;
    pc_op = MCT_PC_HOLD;
    pc_target = '0;
    {reg_wr, rd_flag, chk_d, flag_upd, wdc, slp, wdo} = '0;
    void'($urandom(30342));
    pa = $urandom;
    pb = $urandom;
    pc_pins = $urandom;
    t_cnt = $urandom;
    repeat (3) @(posedge clk);
    #1 sys_rst = 1'b0;
    rd(ADDR_STATUS, 8'h18);
    rd(ADDR_DIRA, 8'h7F);
    chk(a_oe, 8'h00);
    chk(pc, 11'h000);
    // high buffer reaches pc with the low byte write, not on its own write
    wr(ADDR_PCH, 8'h03);
    chk(pc, 11'h000);
    wr(ADDR_PCL, 8'h20);
    chk(pc, 11'h320);
    rd(ADDR_PCH, 8'h03);
    pcop(MCT_PC_JUMP, 11'h123);
    pcop(MCT_PC_CALL, 11'h200);
    pcop(MCT_PC_RET, 11'h000);
    chk(pc, 11'h124);
    pcop(MCT_PC_IRQ, 11'h004);
    chk(pc, 11'h004);
    rd(ADDR_PCH, 8'h01);
    // low-byte wrap pulls in the buffer
    wr(ADDR_PCL, 8'hFF);
    wr(ADDR_PCH, 8'h05);
    pcop(MCT_PC_STEP, 11'h000);
    chk(pc, 11'h500);
    // status flags and locked power bits
    wr(ADDR_STATUS, 8'hFF);
    rd(ADDR_STATUS, 8'h1F);
    flag_upd = 1'b1;
    flag_mask = 3'h4;
    flag_val = 3'h4;
    wr(ADDR_STATUS, 8'h00);
    flag_upd = 1'b0;
    rd(ADDR_STATUS, 8'h1C);
    slp = 1'b1;
    @(posedge clk) #1 slp = 1'b0;
    rd(ADDR_STATUS, 8'h14);
    wdo = 1'b1;
    @(posedge clk) #1 wdo = 1'b0;
    rd(ADDR_STATUS, 8'h04);
    wdc = 1'b1;
    @(posedge clk) #1 wdc = 1'b0;
    rd(ADDR_STATUS, 8'h1C);
    // indirect window
    wr(ADDR_PTR, 8'h48);
    rd(ADDR_WINDOW, 8'h48 ^ 8'hA5);
    wr(ADDR_PTR, 8'h49);
    rd(ADDR_WINDOW, 8'h49 ^ 8'hA5);
    wr(ADDR_PTR, 8'h00);
    rd(ADDR_WINDOW, 8'h00);
    // ports
    wr(ADDR_DIRA, 8'h00);
    wr(ADDR_PORT_A_DATA, 8'hFF);
    chk(a_oe, 8'h7F);
    chk(a_out[6:0], 7'h7F);
    rd(ADDR_PORT_A_DATA, pa);
    wr(ADDR_DIRC, 8'h0F);
    wr(ADDR_PORT_C_DATA, 8'h5A);
    chk(c_oe, 8'hF0);
    chk(c_out, 8'h5A);
    wr(ADDR_DIRB, 8'h00);
    wr(ADDR_PORT_B_DATA, 8'hFF);
    chk(b_oe, 8'h3F);
    chk(b_out, 8'h3F);
    rd(ADDR_PORT_B_DATA, pb & MASK_PORT_B_DATA);
    rd(ADDR_PORT_C_DATA, pc_pins);
    // timer fields
    repeat (4) begin
      v = $urandom;
      wr(ADDR_T1PWM, v);
      rd(ADDR_T1PWM, v & MASK_T1PWM);
      chk({t_mode, p_init, p_ext, irq_rate}, {v[7:5], v[3:0]});
      wr(ADDR_T1RLD, v);
      chk(t_rld, v);
    end
    rd(ADDR_TIMER1_COUNT, t_cnt);
    // each source, with prescale field 0 to 3
    for (int s = 0; s < 4; s++) begin
      wr(ADDR_T1CTL, {2'b10, 2'(s), 1'b0, 3'(s)});
      chk(t_en, 1'b1);
      t0 = ticks;
      repeat (16) pulse(s);
      repeat (4) @(posedge clk);
      #1 chk(11'(ticks - t0), 11'(16 >> s));
    end
    wr(ADDR_T1CTL, 8'h20);
    t0 = ticks;
    repeat (8) pulse(2);
    chk(11'(ticks - t0), 11'h000);
    stop_test();
  end
endmodule // tb
